//--- hdl/pdc_pkg.sv
// constants, fields and types of the phase drive configuration bank
package pdc_pkg;
   // clock rate
   localparam int CLK_MHZ = 200;
   // register offsets
   localparam logic [7:0] OFF_MID_DRIVE = 8'h4e;
   localparam logic [7:0] OFF_LOW_PHASE_RAMP = 8'h4f;
   localparam logic [7:0] OFF_QUICK_RESP = 8'h50;
   localparam logic [7:0] OFF_HOLD_HEIGHT = 8'h54;
   localparam logic [7:0] OFF_BALANCE = 8'h55;
   localparam logic [7:0] OFF_SHED_DELAY = 8'h5d;
   // write lock code held in register 0x00
   localparam logic [7:0] LOCK_CODE = 8'ha6;
   // reset values, and the quick-response off code
   localparam logic [2:0] MID_DRIVE_RST = 3'h5;
   localparam logic [6:0] LOW_PHASE_RAMP_RST = 7'h03;
   localparam logic [7:0] QUICK_RESP_RST = 8'h8f;
   localparam logic [7:0] QUICK_RESP_OFF = 8'h80;
   localparam logic [3:0] HOLD_HEIGHT_RST = 4'h7;
   localparam logic [4:0] BALANCE_RST = 5'h01;
   localparam logic [2:0] SHED_DELAY_RST = 3'h0;
   // field positions
   localparam int MID_RESISTIVE_BIT = 1;
   localparam int MID_TIMED_BIT = 0;
   localparam int LOW_PHASE_LSB = 4;
   localparam int RAMP_LSB = 0;
   localparam int GAIN1_LSB = 3;
   localparam int BAL_DISABLE_BIT = 2;
   localparam int BAL_FILTER_BIT = 1;
   localparam int ANTI_OVERSHOOT_BIT = 0;
   // power-state input levels
   localparam logic [1:0] PWR_STATE_LOW = 2'h0;
   localparam logic [1:0] PWR_STATE_MID = 2'h1;
   // timing
   localparam int MID_DRIVE_NS = 200;
   localparam int MID_DRIVE_CYC = (MID_DRIVE_NS * CLK_MHZ + 999) / 1000;
   localparam int DEGLITCH_STEP_NS = 100;
   localparam int DEGLITCH_STEP_CYC = (DEGLITCH_STEP_NS * CLK_MHZ) / 1000;
   localparam int SHED_BASE_US = 5;
   localparam int SHED_BASE_CYC = SHED_BASE_US * CLK_MHZ;

   typedef struct packed {
      logic [2:0] midDrive;
      logic [6:0] phaseRamp;
      logic [7:0] quickResp;
      logic [3:0] holdHeight;
      logic [4:0] balance;
      logic [2:0] shedDelay;
   } pdc_cfg_t;

   typedef enum logic [1:0] {
      PDC_LOW_STATE,
      PDC_MID_WAIT,
      PDC_AUTO_SHED,
      PDC_HIGH_STATE
   } pdc_mode_t;
endpackage

//--- hdl/pdc_sync3.sv
// three-stage synchroniser that accepts a value once stages two and three agree
`timescale 1ns/1ps
module pdc_sync3 #(
   parameter int WIDTH = 2
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // asynchronous in, settled out
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         stage1 <= '0;
         stage2 <= '0;
         stage3 <= '0;
      end else begin
         stage1 <= din;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         dout <= '0;
      end else if (stage2 == stage3) begin
         dout <= stage3;
      end
   end
endmodule

//--- hdl/pdc_span.sv
// span counter: reports when a condition has held for a given cycle count
`timescale 1ns/1ps
module pdc_span #(
   parameter int WIDTH = 12
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // condition and length
   input wire logic run,
   input wire logic [WIDTH-1:0] limit,
   output logic reached
);
   logic [WIDTH-1:0] count;

   // saturates at the limit so a long hold never wraps
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         count <= '0;
      end else if (!run) begin
         count <= '0;
      end else if (count < limit) begin
         count <= count + 1'b1;
      end
   end

   assign reached = run && (count >= limit);
endmodule

//--- hdl/pdc_config_regs.sv
// phase drive configuration register bank with its drive and timing logic
`timescale 1ns/1ps
module pdc_config_regs #(
   parameter int SHED_BASE_CYC = pdc_pkg::SHED_BASE_CYC
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // register access from the programming bus
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWdata,
   output logic [7:0] regRdata,
   // state of neighbouring registers
   input wire logic [7:0] lockValue,
   input wire logic shedUnlock,
   input wire logic [2:0] shedDeglitchCode,
   input wire logic [1:0] gainSet2,
   // power-state pin, asynchronous
   input wire logic [1:0] power_state_input,
   // loop status, same clock
   input wire logic discontinuous_conduction_mode,
   input wire logic zeroCurrent,
   input wire logic shedRequest,
   // PWM middle drive
   output logic pwmTriDrive,
   output logic pwmFloat,
   // decoded settings
   output pdc_pkg::pdc_cfg_t cfg,
   output logic [3:0] lowStatePhases,
   output logic [10:0] rampMv,
   output logic quickRespOn,
   output logic [4:0] totalGain8,
   output logic balanceOn,
   output logic filterHalf,
   output logic antiOvershootOn,
   // power state and shedding
   output pdc_pkg::pdc_mode_t opMode,
   output logic shedGo
);
   logic [1:0] pwrStateLevel;
   logic unlocked;
   logic wrOk;
   logic shedWrOk;
   logic timedRun;
   logic timedDone;
   logic [7:0] midLimit;
   logic degRun;
   logic degDone;
   logic [11:0] degLimit;
   logic shedRun;
   logic [19:0] shedLimit;
   logic [2:0] shedShift;
   logic [2:0] gainQuarter;
   logic [2:0] gainHalf;
   logic [7:0] next_rdata;
   pdc_pkg::pdc_mode_t next_mode;

   pdc_sync3 #(
      .WIDTH(2)
   ) u_pwr_state_sync (
      .mclk(mclk),
      .rst_b(rst_b),
      .din(power_state_input),
      .dout(pwrStateLevel)
   );

   // write gating
   assign unlocked = (lockValue != pdc_pkg::LOCK_CODE);
   assign wrOk = regWrite && unlocked;
   assign shedWrOk = wrOk && ((opMode == pdc_pkg::PDC_HIGH_STATE)
                              || shedUnlock);

   // register storage; narrow slices drop the unimplemented bits
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cfg.midDrive <= pdc_pkg::MID_DRIVE_RST;
         cfg.phaseRamp <= pdc_pkg::LOW_PHASE_RAMP_RST;
         cfg.quickResp <= pdc_pkg::QUICK_RESP_RST;
         cfg.holdHeight <= pdc_pkg::HOLD_HEIGHT_RST;
         cfg.balance <= pdc_pkg::BALANCE_RST;
         cfg.shedDelay <= pdc_pkg::SHED_DELAY_RST;
      end else if (wrOk) begin
         case (regAddr)
            pdc_pkg::OFF_MID_DRIVE: begin
               cfg.midDrive <= regWdata[2:0];
            end
            pdc_pkg::OFF_LOW_PHASE_RAMP: begin
               cfg.phaseRamp <= regWdata[6:0];
            end
            pdc_pkg::OFF_QUICK_RESP: begin
               cfg.quickResp <= regWdata;
            end
            pdc_pkg::OFF_HOLD_HEIGHT: begin
               cfg.holdHeight <= regWdata[3:0];
            end
            pdc_pkg::OFF_BALANCE: begin
               cfg.balance <= regWdata[4:0];
            end
            pdc_pkg::OFF_SHED_DELAY: begin
               if (shedWrOk) begin
                  cfg.shedDelay <= regWdata[2:0];
               end
            end
            default: begin
            end
         endcase
      end
   end

   // read back; unmapped offsets answer zero
   always_comb begin
      next_rdata = 8'h00;
      case (regAddr)
         pdc_pkg::OFF_MID_DRIVE: begin
            next_rdata = {5'h00, cfg.midDrive};
         end
         pdc_pkg::OFF_LOW_PHASE_RAMP: begin
            next_rdata = {1'b0, cfg.phaseRamp};
         end
         pdc_pkg::OFF_QUICK_RESP: begin
            next_rdata = cfg.quickResp;
         end
         pdc_pkg::OFF_HOLD_HEIGHT: begin
            next_rdata = {4'h0, cfg.holdHeight};
         end
         pdc_pkg::OFF_BALANCE: begin
            next_rdata = {3'h0, cfg.balance};
         end
         pdc_pkg::OFF_SHED_DELAY: begin
            next_rdata = {5'h00, cfg.shedDelay};
         end
         default: begin
            next_rdata = 8'h00;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         regRdata <= 8'h00;
      end else if (regRead) begin
         regRdata <= next_rdata;
      end
   end

   // middle drive; resistive hold overrides the timed window
   assign midLimit = 8'(pdc_pkg::MID_DRIVE_CYC);
   assign timedRun = cfg.midDrive[pdc_pkg::MID_TIMED_BIT]
                     && discontinuous_conduction_mode
                     && zeroCurrent;

   pdc_span #(
      .WIDTH(8)
   ) u_mid_span (
      .mclk(mclk),
      .rst_b(rst_b),
      .run(timedRun),
      .limit(midLimit),
      .reached(timedDone)
   );

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         pwmTriDrive <= 1'b0;
         pwmFloat <= 1'b0;
      end else begin
         pwmTriDrive <= cfg.midDrive[pdc_pkg::MID_RESISTIVE_BIT]
                        || (timedRun && !timedDone);
         pwmFloat <= !cfg.midDrive[pdc_pkg::MID_RESISTIVE_BIT]
                     && timedRun && timedDone;
      end
   end

   // gain decode, result in eighths
   always_comb begin
      gainQuarter = 3'h4 - {1'b0, cfg.balance[pdc_pkg::GAIN1_LSB +: 2]};
      case (gainSet2)
         2'h1: gainHalf = 3'h4;
         2'h2: gainHalf = 3'h1;
         default: gainHalf = 3'h2;
      endcase
   end

   // ramp amplitude lookup
   function automatic logic [10:0] ramp_mv(input logic [3:0] code);
      logic [10:0] mv;
      mv = 11'h000;
      if (!code[3]) begin
         mv = 11'(150 + 50 * int'(code[2:0]));
      end else begin
         case (code[2:0])
            3'h5: mv = 11'(1000);
            3'h6: mv = 11'(1100);
            3'h7: mv = 11'(1300);
            default: mv = 11'(600 + 100 * int'(code[2:0]));
         endcase
      end
      return mv;
   endfunction

   // decoded settings registered for clean outputs
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         lowStatePhases <= 4'h1;
         rampMv <= 11'h12c;
         quickRespOn <= 1'b1;
         totalGain8 <= 5'h08;
         balanceOn <= 1'b1;
         filterHalf <= 1'b0;
         antiOvershootOn <= 1'b1;
      end else begin
         lowStatePhases <= {1'b0,
            cfg.phaseRamp[pdc_pkg::LOW_PHASE_LSB +: 3]} + 4'h1;
         rampMv <= ramp_mv(cfg.phaseRamp[pdc_pkg::RAMP_LSB +: 4]);
         quickRespOn <= (cfg.quickResp != pdc_pkg::QUICK_RESP_OFF);
         totalGain8 <= {2'b00, gainQuarter} * {2'b00, gainHalf};
         balanceOn <= !cfg.balance[pdc_pkg::BAL_DISABLE_BIT];
         filterHalf <= cfg.balance[pdc_pkg::BAL_FILTER_BIT];
         antiOvershootOn <=
            cfg.balance[pdc_pkg::ANTI_OVERSHOOT_BIT];
      end
   end

   // power-state deglitch: 0, then 0.1us doubling per code
   assign degLimit = (shedDeglitchCode == 3'h0) ? 12'h000 :
      (12'(pdc_pkg::DEGLITCH_STEP_CYC) << (shedDeglitchCode - 3'h1));
   assign degRun = (opMode == pdc_pkg::PDC_MID_WAIT);

   pdc_span #(
      .WIDTH(12)
   ) u_deglitch (
      .mclk(mclk),
      .rst_b(rst_b),
      .run(degRun),
      .limit(degLimit),
      .reached(degDone)
   );

   always_comb begin
      next_mode = opMode;
      case (opMode)
         pdc_pkg::PDC_LOW_STATE,
         pdc_pkg::PDC_HIGH_STATE: begin
            if (pwrStateLevel == pdc_pkg::PWR_STATE_MID) begin
               next_mode = pdc_pkg::PDC_MID_WAIT;
            end else if (pwrStateLevel == pdc_pkg::PWR_STATE_LOW) begin
               next_mode = pdc_pkg::PDC_LOW_STATE;
            end else begin
               next_mode = pdc_pkg::PDC_HIGH_STATE;
            end
         end
         pdc_pkg::PDC_MID_WAIT,
         pdc_pkg::PDC_AUTO_SHED: begin
            if (pwrStateLevel == pdc_pkg::PWR_STATE_LOW) begin
               next_mode = pdc_pkg::PDC_LOW_STATE;
            end else if (pwrStateLevel != pdc_pkg::PWR_STATE_MID) begin
               next_mode = pdc_pkg::PDC_HIGH_STATE;
            end else if (degDone) begin
               next_mode = pdc_pkg::PDC_AUTO_SHED;
            end
         end
         default: begin
            next_mode = pdc_pkg::PDC_LOW_STATE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         opMode <= pdc_pkg::PDC_LOW_STATE;
      end else begin
         opMode <= next_mode;
      end
   end

   // shedding delay: all eight codes are 5us times a power of two
   assign shedShift = cfg.shedDelay[2] ? {1'b0, cfg.shedDelay[1:0]}
                      : {1'b0, cfg.shedDelay[1:0]} + 3'h4;
   assign shedLimit = 20'(SHED_BASE_CYC) << shedShift;
   assign shedRun = (opMode == pdc_pkg::PDC_AUTO_SHED) && shedRequest;

   pdc_span #(
      .WIDTH(20)
   ) u_shed_span (
      .mclk(mclk),
      .rst_b(rst_b),
      .run(shedRun),
      .limit(shedLimit),
      .reached(shedGo)
   );

   // checks; one clock domain, so clock and reset are given once
   default clocking cb_chk @(posedge mclk); endclocking
   default disable iff (!rst_b);

   a_lock_blocks_write: assert property (
      regWrite && !unlocked |=> $stable(cfg))
      else $error("locked write changed a field");
   a_shed_gate_closed: assert property (
      regWrite && regAddr == pdc_pkg::OFF_SHED_DELAY
      && opMode != pdc_pkg::PDC_HIGH_STATE && !shedUnlock
      |=> $stable(cfg.shedDelay))
      else $error("shed delay written without power-state permission");
   a_resist_hold_on: assert property (
      cfg.midDrive[1] |=> pwmTriDrive && !pwmFloat)
      else $error("resistive middle drive not held");
   a_timed_tri_span: assert property (
      $rose(timedRun) && !cfg.midDrive[1] |->
      ##40 (pwmTriDrive || !timedRun)
      ##1 ((!pwmTriDrive && pwmFloat) || !timedRun || cfg.midDrive[1]))
      else $error("timed middle drive span is not 200ns");
   a_phase_write_back: assert property (
      wrOk && regAddr == pdc_pkg::OFF_LOW_PHASE_RAMP
      |=> ##1 lowStatePhases == {1'b0, $past(regWdata[6:4], 2)} + 4'h1)
      else $error("low-state phase count wrong after write");
   a_qr_disable_code: assert property (
      wrOk && regAddr == pdc_pkg::OFF_QUICK_RESP && regWdata == 8'h80
      |=> ##1 !quickRespOn)
      else $error("quick response still on after disable code");
   a_gain_product_val: assert property (
      cfg.balance[4:3] == 2'h3 && gainSet2 == 2'h1 |=> totalGain8 == 5'h04)
      else $error("total balance gain not one half");
   a_balance_sense_inv: assert property (
      wrOk && regAddr == pdc_pkg::OFF_BALANCE && regWdata[2]
      |=> ##1 !balanceOn)
      else $error("balance still on after disable bit");
   a_auto_after_wait: assert property (
      $rose(opMode == pdc_pkg::PDC_AUTO_SHED) |-> $past(degDone
         && pwrStateLevel == pdc_pkg::PWR_STATE_MID))
      else $error("auto shedding entered without deglitch wait");
   a_unmapped_zero_rd: assert property (
      regRead && regAddr == 8'h51 |=> regRdata == 8'h00)
      else $error("unmapped offset read non-zero");

   c_locked_write: cover property (regWrite && !unlocked);
   c_auto_entered: cover property ($rose(opMode == pdc_pkg::PDC_AUTO_SHED));
   c_shed_go: cover property ($rose(shedGo));
   c_pwm_float: cover property ($rose(pwmFloat));
endmodule

//--- testbench/pdc_host.sv
// host model driving the register strobes of the configuration bank
`timescale 1ns/1ps
module pdc_host (
   // clock
   input wire logic mclk,
   // register strobes
   output logic regWrite,
   output logic regRead,
   output logic [7:0] regAddr,
   output logic [7:0] regWdata,
   // read answer
   input wire logic [7:0] regRdata
);
   initial begin
      regWrite = 1'b0;
      regRead = 1'b0;
      regAddr = 8'h00;
      regWdata = 8'h00;
   end

   // lock and shed gating are judged by the device; host writes blindly
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      regAddr = a;
      regWdata = d;
      regWrite = 1'b1;
      @(negedge mclk);
      regWrite = 1'b0;
      // stale bus values are inverted so nothing leans on them
      regAddr = ~a;
      regWdata = ~d;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge mclk);
      regAddr = a;
      regRead = 1'b1;
      @(negedge mclk);
      regRead = 1'b0;
      regAddr = ~a;
      d = regRdata;
   endtask
endmodule

//--- testbench/tb_pdc_config_regs.sv
// self-checking bench for the phase drive configuration bank
`timescale 1ns/1ps
module tb_pdc_config_regs;
   localparam int BASE = 4;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic regWrite, regRead, shedUnlock = 1'b0, dcm = 1'b0, zeroCur = 1'b0;
   logic [7:0] regAddr, regWdata, regRdata, lockValue = 8'h00;
   logic [2:0] degl = 3'h0;
   logic [1:0] gainSet2 = 2'h0, pwrState = 2'h0;
   logic shedReq = 1'b0, pwmTriDrive, pwmFloat, quickRespOn, shedGo;
   logic balanceOn, filterHalf, antiOvershootOn;
   pdc_pkg::pdc_cfg_t cfg;
   pdc_pkg::pdc_mode_t opMode;
   logic [3:0] lowStatePhases;
   logic [10:0] rampMv;
   logic [4:0] totalGain8;
   int error_cnt = 0;
   int n_compared = 0;
   int cycles = 0;

   pdc_host i_pdc_host (.mclk(mclk), .regWrite(regWrite), .regRead(regRead),
      .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata));

   pdc_config_regs #(.SHED_BASE_CYC(BASE)) i_pdc_config_regs (.mclk(mclk),
      .rst_b(rst_b), .regWrite(regWrite), .regRead(regRead),
      .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
      .lockValue(lockValue), .shedUnlock(shedUnlock),
      .shedDeglitchCode(degl), .gainSet2(gainSet2),
      .power_state_input(pwrState), .discontinuous_conduction_mode(dcm),
      .zeroCurrent(zeroCur), .shedRequest(shedReq),
      .pwmTriDrive(pwmTriDrive), .pwmFloat(pwmFloat), .cfg(cfg),
      .lowStatePhases(lowStatePhases), .rampMv(rampMv),
      .quickRespOn(quickRespOn), .totalGain8(totalGain8),
      .balanceOn(balanceOn), .filterHalf(filterHalf),
      .antiOvershootOn(antiOvershootOn), .opMode(opMode), .shedGo(shedGo));

   initial begin
      forever #2.5 mclk = ~mclk;
   end

   task automatic close_out;
      $display("compared %0d, errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // generous ceiling: the whole sequence needs well under 3000 cycles
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         error_cnt++;
         close_out();
      end
   end

   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      i_pdc_host.rd(a, d);
      cmp(16'(d), 16'(exp));
   endtask

   task automatic settle;
      repeat (2) @(negedge mclk);
   endtask

   task automatic t_reset_values;
      rdchk(8'h4e, 8'h05);
      rdchk(8'h4f, 8'h03);
      rdchk(8'h50, 8'h8f);
      rdchk(8'h54, 8'h07);
      rdchk(8'h55, 8'h01);
      rdchk(8'h5d, 8'h00);
      rdchk(8'h4b, 8'h00);
      rdchk(8'h51, 8'h00);
      cmp(16'(rampMv), 16'h12c);
   endtask

   // ramp table, with the boundary codes of the phase field
   task automatic t_ramp_phases;
      int mv;
      for (int c = 0; c < 16; c++) begin
         mv = c < 8 ? 150 + 50 * c : c < 13 ? 600 + 100 * (c - 8) :
            c == 13 ? 1000 : c == 14 ? 1100 : 1300;
         i_pdc_host.wr(8'h4f, 8'(c | (c << 4) | 8'h80));
         settle();
         cmp(16'(rampMv), 16'(mv));
         cmp(16'(lowStatePhases), 16'((c & 7) + 1));
      end
      rdchk(8'h4f, 8'h7f);
   endtask

   task automatic t_lock;
      lockValue = pdc_pkg::LOCK_CODE;
      i_pdc_host.wr(8'h54, 8'h03);
      i_pdc_host.wr(8'h50, 8'h80);
      rdchk(8'h54, 8'h07);
      rdchk(8'h50, 8'h8f);
      lockValue = 8'ha7;
      i_pdc_host.wr(8'h54, 8'hf3);
      rdchk(8'h54, 8'h03);
      cmp(16'(cfg.holdHeight), 16'h3);
   endtask

   task automatic t_quick;
      i_pdc_host.wr(8'h50, 8'h80);
      settle();
      cmp(16'(quickRespOn), 16'h0);
      i_pdc_host.wr(8'h50, 8'h8f);
      settle();
      cmp(16'(quickRespOn), 16'h1);
   endtask

   task automatic t_balance;
      logic [2:0] lo;
      int g;
      for (int g1 = 0; g1 < 4; g1++) begin
         for (int g2 = 0; g2 < 4; g2++) begin
            lo = 3'(g1 + g2);
            gainSet2 = 2'(g2);
            i_pdc_host.wr(8'h55, 8'((g1 << 3) | lo));
            settle();
            g = 8 - 2 * g1;
            g = g2 == 1 ? g * 2 : g2 == 2 ? g / 2 : g;
            cmp(16'(totalGain8), 16'(g));
            cmp(16'(balanceOn), 16'(!lo[2]));
            cmp(16'(filterHalf), 16'(lo[1]));
            cmp(16'(antiOvershootOn), 16'(lo[0]));
         end
      end
   endtask

   task automatic t_mid_drive;
      int n;
      n = 0;
      i_pdc_host.wr(8'h4e, 8'h01);
      dcm = 1'b1;
      zeroCur = 1'b1;
      repeat (2) @(negedge mclk);
      while (pwmTriDrive === 1'b1 && n < 100) begin
         n++;
         @(negedge mclk);
      end
      cmp(16'(n + 1), 16'(pdc_pkg::MID_DRIVE_CYC));
      cmp(16'(pwmFloat), 16'h1);
      zeroCur = 1'b0;
      i_pdc_host.wr(8'h4e, 8'h02);
      settle();
      cmp(16'({pwmTriDrive, pwmFloat}), 16'h2);
      i_pdc_host.wr(8'h4e, 8'h05);
      rdchk(8'h4e, 8'h05);
      dcm = 1'b0;
   endtask

   // shed field opened by high power state, then by the unlock bit;
   // middle level with 40-cycle deglitch, then the two shed delays
   task automatic t_shed;
      int n;
      i_pdc_host.wr(8'h5d, 8'h04);
      rdchk(8'h5d, 8'h00);
      pwrState = 2'h2;
      repeat (6) @(negedge mclk);
      cmp(16'(opMode), 16'(pdc_pkg::PDC_HIGH_STATE));
      i_pdc_host.wr(8'h5d, 8'h05);
      rdchk(8'h5d, 8'h05);
      pwrState = pdc_pkg::PWR_STATE_LOW;
      repeat (6) @(negedge mclk);
      shedUnlock = 1'b1;
      i_pdc_host.wr(8'h5d, 8'h04);
      rdchk(8'h5d, 8'h04);
      degl = 3'h2;
      pwrState = pdc_pkg::PWR_STATE_MID;
      n = 0;
      while (opMode !== pdc_pkg::PDC_AUTO_SHED && n < 100) begin
         n++;
         @(negedge mclk);
      end
      cmp(16'(n >= 41 && n <= 47), 16'h1);
      for (int k = 0; k < 2; k++) begin
         shedReq = 1'b0;
         i_pdc_host.wr(8'h5d, k == 0 ? 8'h04 : 8'h00);
         @(negedge mclk);
         shedReq = 1'b1;
         n = 0;
         while (shedGo !== 1'b1 && n < 200) begin
            n++;
            @(negedge mclk);
         end
         g_chk_shed(n, k == 0 ? BASE : BASE << 4);
      end
      shedReq = 1'b0;
      pwrState = pdc_pkg::PWR_STATE_LOW;
   endtask

   task automatic g_chk_shed(input int n, input int exp);
      cmp(16'(n >= exp && n <= exp + 2), 16'h1);
   endtask

   initial begin
      repeat (6) @(negedge mclk);
      rst_b = 1'b1;
      t_reset_values();
      t_ramp_phases();
      t_lock();
      t_quick();
      t_balance();
      t_mid_drive();
      t_shed();
      close_out();
   end
endmodule
